// file: logic/cog_pkg.sv
// Package: constants and types for the clock output group control block
// ----------------------------------------------------------------------------
// Behaviour
// - Six registers, each controls one output pair
// - Bit 31 powers down whole group
// - Bit 30 selects source, groups 3,4 only
// - Bits 28/29 route analog delay; none powers down
// - Both outputs share one analog delay value
// - Digital delay field, values 0-5 give 5
// - New delay applied on sync, unexcluded groups
// - Delay 13 or more means extended mode
// - Delay cycle is distribution clock period
// - Half-step bit subtracts half a cycle
// - Half-step change acts immediately
// - Divide field gives 50% duty, 0 reserved
// - Divide 26 or more means extended mode
// - Register 0 reset bit reloads defaults
// - Soft reset on latch-enable falling edge
// - Reset bit cleared by any other write
// - Register 1 bit 17 powers device down
// ----------------------------------------------------------------------------
package cog_pkg;
    localparam int COG_GROUPS = 6;
    localparam int COG_WORD_W = 32;
    localparam int COG_ADDR_W = 5;
    localparam int COG_DATA_W = 27;
    localparam logic [4:0] COG_REG_GROUP0 = 5'h00;
    localparam logic [4:0] COG_REG_GROUP1 = 5'h01;
    localparam logic [4:0] COG_REG_GROUP2 = 5'h02;
    localparam logic [4:0] COG_REG_GROUP3 = 5'h03;
    localparam logic [4:0] COG_REG_GROUP4 = 5'h04;
    localparam logic [4:0] COG_REG_GROUP5 = 5'h05;
    localparam int COG_PD_BIT = 31;
    localparam int COG_SRC_BIT = 30;
    localparam int COG_ODD_ADLY_BIT = 29;
    localparam int COG_EVEN_ADLY_BIT = 28;
    localparam int COG_DDLY_MSB = 27;
    localparam int COG_DDLY_LSB = 18;
    localparam int COG_RESET_BIT = 17;
    localparam int COG_DEVPD_BIT = 17;
    localparam int COG_HS_BIT = 16;
    localparam int COG_DIV_MSB = 15;
    localparam int COG_DIV_LSB = 5;
    localparam logic [9:0] COG_DDLY_MIN = 10'h005;
    localparam logic [9:0] COG_DDLY_EXT = 10'h00D;
    localparam logic [10:0] COG_DIV_EXT = 11'h01A;
    // Silicon defaults per group: pd, src, div
    localparam logic [5:0] COG_RST_PD = 6'h27;
    localparam logic [5:0] COG_RST_SRC = 6'h08;
    localparam logic [10:0] COG_RST_DIV = 11'h019;
    localparam logic [10:0] COG_RST_DIV_G3 = 11'h001;
    localparam logic [9:0] COG_RST_DDLY = 10'h000;
    localparam logic [5:0] COG_RST_NOSYNC = 6'h18;
endpackage : cog_pkg

// file: logic/cog_divider.sv
// Module: one group's divider with half-cycle delay, half-step trim and 50% duty
`timescale 1ns/1ps
module cog_divider (
    input wire logic i_clk_sys,          // Distribution clock
    input wire logic i_rst,              // Sync reset
    input wire logic i_run,              // Group powered
    input wire logic i_sync,             // Realign pulse
    input wire logic [10:0] i_div,       // Divide value
    input wire logic [9:0] i_ddly,       // Applied delay cycles
    input wire logic i_half_step,        // Subtract half cycle
    output logic o_clk                   // Divided clock
);
    // ----------------------------------------------------------------------------
    // Counters
    // ----------------------------------------------------------------------------
    logic [10:0] phase_r;
    logic [9:0] wait_r;
    logic pos_r;
    logic neg_r;
    logic pos_lo_r;
    logic neg_lo_r;
    logic [10:0] div_eff;
    logic [10:0] high_cnt;
    assign div_eff = (i_div == 11'h000) ? 11'h001 : i_div;
    assign high_cnt = div_eff >> 1;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst || !i_run) begin
            wait_r <= 10'h000;
            phase_r <= 11'h000;
        end else if (i_sync) begin
            wait_r <= (i_ddly < cog_pkg::COG_DDLY_MIN) ? cog_pkg::COG_DDLY_MIN : i_ddly;
            phase_r <= 11'h000;
        end else if (wait_r != 10'h000) begin
            wait_r <= wait_r - 10'h001;
        end else if (phase_r == div_eff - 11'h001) begin
            phase_r <= 11'h000;
        end else begin
            phase_r <= phase_r + 11'h001;
        end
    end

    // Odd ratios: long window ANDed with its falling-edge copy, or short window ORed
    // with its copy, both give half-cycle high time; sync blanks the stale window
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || !i_run || i_sync || wait_r != 10'h000) begin
            pos_r <= 1'b0;
            pos_lo_r <= 1'b0;
        end else if (div_eff == 11'h001) begin
            pos_r <= 1'b1;
            pos_lo_r <= 1'b1;
        end else begin
            pos_r <= (phase_r < (div_eff - high_cnt));
            pos_lo_r <= (phase_r < high_cnt);
        end
    end

    always_ff @(negedge i_clk_sys) begin
        if (i_rst) begin
            neg_r <= 1'b0;
            neg_lo_r <= 1'b0;
        end else begin
            neg_r <= pos_r;
            neg_lo_r <= pos_lo_r;
        end
    end

    // Half step: advance by half a cycle via the rising-edge sample; takes effect at once
    always_comb begin
        if (div_eff == 11'h001) begin
            o_clk = pos_r & i_clk_sys;
        end else if (i_half_step) begin
            o_clk = div_eff[0] ? (pos_lo_r | neg_lo_r) : pos_r;
        end else begin
            o_clk = div_eff[0] ? (pos_r & neg_r) : neg_r;
        end
    end
endmodule // cog_divider

// file: logic/cog_top.sv
// Module: serial-loaded control of six clock output groups
`timescale 1ns/1ps
module cog_top #(
    parameter int GROUPS = cog_pkg::COG_GROUPS
) (
    input wire logic i_clk_sys,                  // Distribution-path clock
    input wire logic i_rst,                      // Sync reset, high
    input wire logic i_ser_clk,                  // Serial clock pin
    input wire logic i_ser_data,                 // Serial data pin
    input wire logic i_latch_enable_pin,         // Latch enable pin
    input wire logic i_sync,                     // Sync event pulse
    input wire logic [GROUPS-1:0] i_group_sync_exclude, // Per-group sync exclude
    input wire logic i_reference_oscillator_input, // Oscillator buffer clock
    output logic [GROUPS-1:0] o_even_output,     // Even outputs
    output logic [GROUPS-1:0] o_odd_output,      // Odd outputs
    output logic [GROUPS-1:0] o_group_powerdown, // Group powered down
    output logic [GROUPS-1:0] o_group_source_select, // 1 = oscillator source
    output logic [GROUPS-1:0] o_even_analog_delay_select, // Even uses analog delay
    output logic [GROUPS-1:0] o_odd_analog_delay_select,  // Odd uses analog delay
    output logic [GROUPS-1:0] o_analog_delay_on, // Shared analog delay powered
    output logic [GROUPS-1:0] o_extended_mode,   // Extended power mode
    output logic o_device_powerdown              // Whole device down
);
    // ----------------------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------------------
    logic [2:0] pin_meta_r;
    logic [2:0] pin_sync_r;
    logic sclk_d_r;
    logic le_d_r;
    logic [GROUPS-1:0] osc_meta_r;
    logic [GROUPS-1:0] osc_sync_r;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            pin_meta_r <= 3'h0;
            pin_sync_r <= 3'h0;
            sclk_d_r <= 1'b0;
            le_d_r <= 1'b0;
        end else begin
            pin_meta_r <= {i_latch_enable_pin, i_ser_data, i_ser_clk};
            pin_sync_r <= pin_meta_r;
            sclk_d_r <= pin_sync_r[0];
            le_d_r <= pin_sync_r[2];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            osc_meta_r <= '0;
            osc_sync_r <= '0;
        end else begin
            osc_meta_r <= {GROUPS{i_reference_oscillator_input}};
            osc_sync_r <= osc_meta_r;
        end
    end

    logic sclk_rise;
    logic le_fall;
    assign sclk_rise = pin_sync_r[0] & ~sclk_d_r;
    assign le_fall = ~pin_sync_r[2] & le_d_r;

    // ----------------------------------------------------------------------------
    // Serial shifter: data then 5-bit address, MSB first
    // ----------------------------------------------------------------------------
    logic [cog_pkg::COG_WORD_W-1:0] shift_r;
    logic [5:0] bits_r;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst || le_fall) begin
            bits_r <= 6'h00;
        end else if (sclk_rise && !pin_sync_r[2] && bits_r != 6'h3F) begin
            bits_r <= bits_r + 6'h01;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            shift_r <= '0;
        end else if (sclk_rise && !pin_sync_r[2]) begin
            shift_r <= {shift_r[cog_pkg::COG_WORD_W-2:0], pin_sync_r[1]};
        end
    end

    // Word lands only on the latch-enable falling edge after a full shift
    logic word_done;
    logic [4:0] wr_addr;
    assign word_done = le_fall && (bits_r >= 6'h20);
    assign wr_addr = shift_r[cog_pkg::COG_ADDR_W-1:0];

    // ----------------------------------------------------------------------------
    // Group registers
    // ----------------------------------------------------------------------------
    logic [GROUPS-1:0] pd_r;
    logic [GROUPS-1:0] src_r;
    logic [GROUPS-1:0] even_adly_r;
    logic [GROUPS-1:0] odd_adly_r;
    logic [GROUPS-1:0] hs_r;
    logic [9:0] ddly_r [GROUPS];
    logic [10:0] div_r [GROUPS];
    logic reset_bit_r;
    logic dev_pd_r;
    logic soft_rst;

    assign soft_rst = word_done && (wr_addr == cog_pkg::COG_REG_GROUP0)
        && shift_r[cog_pkg::COG_RESET_BIT];

    function automatic logic [10:0] cog_default_div(input int g);
        cog_default_div = (g == 3) ? cog_pkg::COG_RST_DIV_G3 : cog_pkg::COG_RST_DIV;
    endfunction

    always_ff @(posedge i_clk_sys) begin
        for (int g = 0; g < GROUPS; g++) begin
            if (i_rst || soft_rst) begin
                pd_r[g] <= cog_pkg::COG_RST_PD[g];
                src_r[g] <= cog_pkg::COG_RST_SRC[g];
                even_adly_r[g] <= 1'b0;
                odd_adly_r[g] <= 1'b0;
                hs_r[g] <= 1'b0;
                ddly_r[g] <= cog_pkg::COG_RST_DDLY;
                div_r[g] <= cog_default_div(g);
            end else if (word_done && wr_addr == 5'(g)) begin
                pd_r[g] <= shift_r[cog_pkg::COG_PD_BIT];
                src_r[g] <= (g == 3 || g == 4) ? shift_r[cog_pkg::COG_SRC_BIT] : 1'b0;
                even_adly_r[g] <= shift_r[cog_pkg::COG_EVEN_ADLY_BIT];
                odd_adly_r[g] <= shift_r[cog_pkg::COG_ODD_ADLY_BIT];
                hs_r[g] <= shift_r[cog_pkg::COG_HS_BIT];
                ddly_r[g] <= shift_r[cog_pkg::COG_DDLY_MSB:cog_pkg::COG_DDLY_LSB];
                div_r[g] <= shift_r[cog_pkg::COG_DIV_MSB:cog_pkg::COG_DIV_LSB];
            end
        end
    end

    // Reset bit self-clears on the next write of any register
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            reset_bit_r <= 1'b0;
        end else if (soft_rst) begin
            reset_bit_r <= 1'b1;
        end else if (word_done) begin
            reset_bit_r <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst || soft_rst) begin
            dev_pd_r <= 1'b0;
        end else if (word_done && wr_addr == cog_pkg::COG_REG_GROUP1) begin
            dev_pd_r <= shift_r[cog_pkg::COG_DEVPD_BIT];
        end
    end

    // Delay reaches the divider only at a sync event on unexcluded groups;
    // the divider samples the stored value on that very edge
    logic [GROUPS-1:0] sync_grp;
    always_comb begin
        for (int g = 0; g < GROUPS; g++) begin
            sync_grp[g] = i_sync & ~i_group_sync_exclude[g];
        end
    end

    // ----------------------------------------------------------------------------
    // Per-group datapath
    // ----------------------------------------------------------------------------
    logic [GROUPS-1:0] run;
    logic [GROUPS-1:0] div_clk;
    logic [GROUPS-1:0] grp_clk;

    function automatic logic cog_extended(input logic [9:0] dly, input logic [10:0] dv);
        cog_extended = (dly >= cog_pkg::COG_DDLY_EXT) || (dv >= cog_pkg::COG_DIV_EXT);
    endfunction

    // One divider cycle equals one distribution clock, which is i_clk_sys here
    genvar gi;
    generate
        for (gi = 0; gi < GROUPS; gi++) begin : g_grp
            assign run[gi] = ~pd_r[gi] & ~dev_pd_r;
            cog_divider u_div (
                .i_clk_sys(i_clk_sys),
                .i_rst(i_rst),
                .i_run(run[gi]),
                .i_sync(sync_grp[gi]),
                .i_div(div_r[gi]),
                .i_ddly(ddly_r[gi]),
                .i_half_step(hs_r[gi]),
                .o_clk(div_clk[gi])
            );
            assign grp_clk[gi] = src_r[gi] ? osc_sync_r[gi] : div_clk[gi];
        end
    endgenerate

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_group_powerdown <= '1;
            o_group_source_select <= '0;
            o_even_analog_delay_select <= '0;
            o_odd_analog_delay_select <= '0;
            o_analog_delay_on <= '0;
            o_extended_mode <= '0;
            o_device_powerdown <= 1'b0;
        end else begin
            o_group_powerdown <= ~run;
            o_group_source_select <= src_r;
            o_even_analog_delay_select <= even_adly_r & run;
            o_odd_analog_delay_select <= odd_adly_r & run;
            // One shared delay line per group feeds both outputs
            o_analog_delay_on <= (even_adly_r | odd_adly_r) & run;
            for (int g = 0; g < GROUPS; g++) begin
                o_extended_mode[g] <= cog_extended(ddly_r[g], div_r[g]);
            end
            o_device_powerdown <= dev_pd_r;
        end
    end

    // Output buffers are gated off while the group is down
    assign o_even_output = grp_clk & run;
    assign o_odd_output = grp_clk & run;
endmodule // cog_top

// file: testbench/cog_top_props.sv
// Checker: port-level properties of the clock output group control block
`timescale 1ns/1ps
module cog_top_props #(
    parameter int GROUPS = cog_pkg::COG_GROUPS
) (
    input wire logic i_clk_sys, // Clock
    input wire logic i_rst, // Sync reset
    input wire logic i_ser_clk, // Serial clock
    input wire logic i_ser_data, // Serial data
    input wire logic i_latch_enable_pin, // Latch enable
    input wire logic i_sync, // Sync pulse
    input wire logic [GROUPS-1:0] i_group_sync_exclude, // Exclude
    input wire logic i_reference_oscillator_input, // Oscillator
    input wire logic [GROUPS-1:0] o_even_output, // Even clocks
    input wire logic [GROUPS-1:0] o_odd_output, // Odd clocks
    input wire logic [GROUPS-1:0] o_group_powerdown, // Group down
    input wire logic [GROUPS-1:0] o_group_source_select, // Source
    input wire logic [GROUPS-1:0] o_even_analog_delay_select, // Even select
    input wire logic [GROUPS-1:0] o_odd_analog_delay_select, // Odd select
    input wire logic [GROUPS-1:0] o_analog_delay_on, // Delay powered
    input wire logic [GROUPS-1:0] o_extended_mode, // Extended mode
    input wire logic o_device_powerdown // Device down
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);
    // Cycles since the latch-enable pin fell; settings may only move shortly after
    logic le_q;
    logic [3:0] age_r;
    always_ff @(posedge i_clk_sys) begin
        le_q <= i_latch_enable_pin;
        if (i_rst || (le_q && !i_latch_enable_pin)) begin
            age_r <= 4'h0;
        end else if (age_r != 4'hF) begin
            age_r <= age_r + 4'h1;
        end
    end
    a_pd_after_reset:
        assert property ($past(i_rst) |-> &o_group_powerdown && o_extended_mode == '0 && !o_device_powerdown)
        else $error("group powerdown not set out of reset");
    a_source_two_groups:
        assert property ((o_group_source_select & ~6'h18) == '0)
        else $error("source select set outside groups 3 and 4");
    a_analog_needs_select:
        assert property ((o_analog_delay_on & ~(o_even_analog_delay_select | o_odd_analog_delay_select)) == '0)
        else $error("analog delay powered with no select");
    a_down_outputs_low:
        assert property ((o_group_powerdown & ($past(o_even_output) | $past(o_odd_output))) == '0)
        else $error("output toggles in a powered-down group");
    a_device_down_all:
        assert property (o_device_powerdown && $past(o_device_powerdown) |-> &o_group_powerdown)
        else $error("device powerdown leaves a group running");
    a_load_at_latch:
        assert property (!$stable({o_group_source_select, o_group_powerdown, o_extended_mode,
                o_even_analog_delay_select, o_odd_analog_delay_select, o_device_powerdown}) |-> age_r <= 4'hA)
        else $error("settings changed away from a latch-enable fall");
    a_sync_min_delay:
        assert property (i_sync |-> ##2 (((o_even_output | o_odd_output) & ~i_group_sync_exclude
                & ~o_group_source_select) == '0) [*3])
        else $error("output started before the minimum delay");
    a_select_in_reset:
        assert property ($past(i_rst) |-> (o_even_analog_delay_select | o_odd_analog_delay_select) == '0)
        else $error("analog select not cleared by reset");
endmodule // cog_top_props
bind cog_top cog_top_props #(.GROUPS(GROUPS)) u_props (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_ser_clk(i_ser_clk), .i_ser_data(i_ser_data), .i_latch_enable_pin(i_latch_enable_pin),
    .i_sync(i_sync), .i_group_sync_exclude(i_group_sync_exclude),
    .i_reference_oscillator_input(i_reference_oscillator_input), .o_even_output(o_even_output),
    .o_odd_output(o_odd_output), .o_group_powerdown(o_group_powerdown),
    .o_group_source_select(o_group_source_select), .o_even_analog_delay_select(o_even_analog_delay_select),
    .o_odd_analog_delay_select(o_odd_analog_delay_select), .o_analog_delay_on(o_analog_delay_on),
    .o_extended_mode(o_extended_mode), .o_device_powerdown(o_device_powerdown));

// file: testbench/cog_host_model.sv
// Host model: shifts configuration words into the block over the serial pins
`timescale 1ns/1ps
module cog_host_model (
    input wire logic i_clk_sys, // Pacing clock
    output logic o_ser_clk, // Serial clock
    output logic o_ser_data, // Serial data
    output logic o_latch_enable_pin // Latch enable
);
    initial begin
        o_ser_clk = 1'b0;
        o_ser_data = 1'b0;
        o_latch_enable_pin = 1'b0;
    end
    // Three system clocks per phase so the two-stage synchroniser never misses one
    task automatic send(input logic [31:0] word, input int bits);
        for (int i = bits - 1; i >= 0; i--) begin
            o_ser_data = word[i];
            repeat (3) @(negedge i_clk_sys);
            o_ser_clk = 1'b1;
            repeat (3) @(negedge i_clk_sys);
            o_ser_clk = 1'b0;
        end
        repeat (3) @(negedge i_clk_sys);
        o_latch_enable_pin = 1'b1;
        repeat (3) @(negedge i_clk_sys);
        o_latch_enable_pin = 1'b0;
        o_ser_data = ~o_ser_data;
    endtask
endmodule // cog_host_model

// file: testbench/tb_top.sv
// Testbench: self-checking scenarios for the clock output group control block
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sync = 1'b0;
    logic osc = 1'b0;
    logic [5:0] excl = 6'h00;
    logic ser_clk, ser_data, le, dpd;
    logic [5:0] even, odd, gpd, src, esel, osel, aon, ext;
    int errors = 0;
    int check_count = 0;
    always #50 clk = ~clk;
    always #165 osc = ~osc;
    cog_host_model host (.i_clk_sys(clk), .o_ser_clk(ser_clk), .o_ser_data(ser_data), .o_latch_enable_pin(le));
    cog_top #(.GROUPS(6)) dut (.i_clk_sys(clk), .i_rst(rst), .i_ser_clk(ser_clk), .i_ser_data(ser_data),
        .i_latch_enable_pin(le), .i_sync(sync), .i_group_sync_exclude(excl),
        .i_reference_oscillator_input(osc), .o_even_output(even), .o_odd_output(odd),
        .o_group_powerdown(gpd), .o_group_source_select(src), .o_even_analog_delay_select(esel),
        .o_odd_analog_delay_select(osel), .o_analog_delay_on(aon), .o_extended_mode(ext),
        .o_device_powerdown(dpd));
    task automatic results;
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %0h seen %0h", name, exp, got);
        end
    endtask
    function automatic logic [31:0] w(logic pd, logic s, logic o, logic e, logic [9:0] dd, logic b17,
            logic hs, logic [10:0] dv, logic [4:0] a);
        return {pd, s, o, e, dd, b17, hs, dv, a};
    endfunction
    task automatic wr(input logic [31:0] word);
        host.send(word, 32);
        repeat (8) @(negedge clk);
    endtask
    // Polls at 1 ns so edges made on either clock edge are timed alike
    task automatic edge_at(input int g, input logic v, output longint t);
        int i;
        for (i = 0; i < 3000 && even[g] === v; i++) #1;
        for (; i < 3000 && even[g] !== v; i++) #1;
        if (i >= 3000) begin
            errors++;
            results();
        end else t = $time;
    endtask
    task automatic s_reset;
        chk("powerdown", 6'h27, gpd);
        chk("source", 6'h08, src);
        chk("extended", 6'h00, ext);
        chk("analog on", 6'h00, aon);
        chk("device pd", 1'b0, dpd);
    endtask
    task automatic s_groups;
        for (int g = 0; g < 6; g++) wr(w(0, 1, g[0], !(g == 1 || g == 2), 0, 0, 0, 4, g[4:0]));
        chk("powerdown", 6'h00, gpd);
        chk("source", 6'h18, src);
        chk("even select", 6'h39, esel);
        chk("odd select", 6'h2A, osel);
        chk("analog on", 6'h3B, aon);
        chk("extended", 6'h00, ext);
    endtask
    task automatic s_ext;
        logic [9:0] dd[4] = '{12, 13, 5, 0};
        logic [10:0] dv[4] = '{25, 2, 26, 1};
        logic x[4] = '{0, 1, 1, 0};
        // Half step only with divide above one
        for (int i = 0; i < 4; i++) begin
            wr(w(0, 0, 0, 0, dd[i], 0, i == 1, dv[i], 5'h02));
            chk("extended", x[i], ext[2]);
        end
    endtask
    task automatic s_refuse;
        host.send(w(1, 0, 0, 0, 0, 0, 0, 4, 5'h02), 31);
        repeat (8) @(negedge clk);
        chk("short word", 6'h00, gpd);
        wr(w(1, 0, 0, 0, 0, 0, 0, 4, 5'h06));
        chk("unmapped", 6'h00, gpd);
    endtask
    task automatic s_devpd;
        wr(w(0, 0, 0, 0, 0, 1, 0, 4, 5'h01));
        chk("device pd", 1'b1, dpd);
        chk("powerdown", 6'h3F, gpd);
        wr(w(0, 0, 0, 0, 0, 0, 0, 4, 5'h01));
        chk("device pd", 1'b0, dpd);
        chk("powerdown", 6'h00, gpd);
    endtask
    task automatic s_soft;
        wr(w(0, 1, 1, 1, 10'h00D, 1, 0, 11'h01A, 5'h00));
        chk("powerdown", 6'h27, gpd);
        chk("source", 6'h08, src);
        chk("even select", 6'h00, esel);
        chk("extended", 6'h00, ext);
        wr(w(0, 0, 0, 0, 0, 0, 0, 4, 5'h00));
        chk("powerdown", 6'h26, gpd);
    endtask
    task automatic s_div;
        longint t0, t1, t2, t3;
        int dv[2] = '{3, 4};
        for (int i = 0; i < 2; i++) begin
            wr(w(0, 0, 0, 0, 7, 0, 0, dv[i][10:0], 5'h05));
            sync = 1'b1;
            @(negedge clk);
            sync = 1'b0;
            edge_at(5, 1'b1, t0);
            edge_at(5, 1'b0, t1);
            edge_at(5, 1'b1, t2);
            chk("odd output", 1'b1, odd[5]);
            chk("period", dv[i] * 100, t2 - t0);
            chk("high time", dv[i] * 50, t1 - t0);
        end
        wr(w(0, 0, 0, 0, 7, 0, 1, 4, 5'h05));
        edge_at(5, 1'b1, t3);
        chk("half step", 350, (t3 - t2) % 400);
    endtask
    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        s_reset();
        s_groups();
        s_ext();
        s_refuse();
        s_devpd();
        s_soft();
        s_div();
        results();
    end
    initial begin
        #5000000;
        errors++;
        results();
    end
endmodule // tb_top
